/* File: core/sio_port.sv */
// Six-bit I/O port: AXI4-Lite registers, pin mux shared with two serial channels.
// Assumes pins and serial controls are synchronous to sys_clk.
`timescale 1ns/1ps
`default_nettype none

module sio_port #(
    parameter int ADDR_W = 20
)
(
    input wire logic sys_clk,
    input wire logic rst_b,
    input wire logic hw_standby,
    input wire logic awvalid,
    output logic awready,
    input wire logic [ADDR_W-1:0] awaddr,
    input wire logic [2:0] awprot,
    input wire logic wvalid,
    output logic wready,
    input wire logic [sio_pkg::DATA_W-1:0] wdata,
    input wire logic [3:0] wstrb,
    output logic bvalid,
    input wire logic bready,
    output logic [1:0] bresp,
    input wire logic arvalid,
    output logic arready,
    input wire logic [ADDR_W-1:0] araddr,
    input wire logic [2:0] arprot,
    output logic rvalid,
    input wire logic rready,
    output logic [sio_pkg::DATA_W-1:0] rdata,
    output logic [1:0] rresp,
    input wire logic [sio_pkg::PORT_W-1:0] pin_in,
    output logic [sio_pkg::PORT_W-1:0] pin_out,
    output logic [sio_pkg::PORT_W-1:0] pin_oe,
    input wire sio_pkg::sio_ser_ctrl_t ctrl_ch0,
    input wire sio_pkg::sio_ser_ctrl_t ctrl_ch1,
    output sio_pkg::sio_ser_ret_t ret_ch0,
    output sio_pkg::sio_ser_ret_t ret_ch1
);
    import sio_pkg::*;

    if (ADDR_W < MIN_ADDR_W)
    begin : g_bad_addr_w
        $error("ADDR_W too small to reach the highest register");
    end

    sio_state_t q;
    sio_state_t next_q;
    logic wr_fire;
    logic ar_fire;
    sio_sel_t ar_sel;
    logic [PORT_W-1:0] readback;
    logic [PORT_W-1:0] drive;
    logic [PORT_W-1:0] val;
    sio_pin_fn_t fn_serial_clock_ch0;
    sio_pin_fn_t fn_serial_clock_ch1;

    // Shared by the read and write paths; protection bits are not checked
    function automatic sio_sel_t decode(input logic [ADDR_W-1:0] addr);
        logic [ADDR_W-3:0] idx;
        idx = addr[ADDR_W-1:2];
        if (addr[1:0] != 2'h0)
            decode = SEL_NONE;
        else if (idx == (ADDR_W-2)'(IDX_PIN_DIRECTION))
            decode = SEL_DIR;
        else if (idx == (ADDR_W-2)'(IDX_PIN_LEVEL_READBACK))
            decode = SEL_PIN;
        else if (idx == (ADDR_W-2)'(IDX_OUTPUT_LATCH))
            decode = SEL_LAT;
        else if (idx == (ADDR_W-2)'(IDX_OPEN_DRAIN_SELECT))
            decode = SEL_OD;
        else
            decode = SEL_NONE;
    endfunction

    // Same selection for both clock pins, only the channel differs
    function automatic sio_pin_fn_t clk_pin_fn(input sio_ser_ctrl_t c);
        if (c.clk_enable_high_bit)
            clk_pin_fn = PF_SER_IN;
        else if (c.sync_mode || c.clk_enable_low_bit)
            clk_pin_fn = PF_SER_OUT;
        else
            clk_pin_fn = PF_GPIO;
    endfunction

    assign wr_fire = q.aw_got && q.w_got && !q.bvalid;
    assign ar_fire = arvalid && q.arready;
    assign ar_sel = decode(araddr);
    assign fn_serial_clock_ch0 = clk_pin_fn(ctrl_ch0);
    assign fn_serial_clock_ch1 = clk_pin_fn(ctrl_ch1);

    // Output pins read back the latch, input pins the live level
    assign readback = (q.pin_direction & q.output_latch) | (~q.pin_direction & pin_in);

    // The sync_mode input feeds the clock pin selection through clk_pin_fn
    always_comb
    begin
        drive = q.pin_direction;
        val = q.output_latch;
        if (ctrl_ch0.transmit_enable)
        begin
            drive[PIN_TRANSMIT_DATA_CH0] = 1'b1;
            val[PIN_TRANSMIT_DATA_CH0] = ctrl_ch0.transmit_data;
        end
        if (ctrl_ch1.transmit_enable)
        begin
            drive[PIN_TRANSMIT_DATA_CH1] = 1'b1;
            val[PIN_TRANSMIT_DATA_CH1] = ctrl_ch1.transmit_data;
        end
        if (ctrl_ch0.receive_enable)
            drive[PIN_RECEIVE_DATA_CH0] = 1'b0;
        if (ctrl_ch1.receive_enable)
            drive[PIN_RECEIVE_DATA_CH1] = 1'b0;
        if (fn_serial_clock_ch0 == PF_SER_OUT)
        begin
            drive[PIN_SERIAL_CLOCK_CH0] = 1'b1;
            val[PIN_SERIAL_CLOCK_CH0] = ctrl_ch0.serial_clock_out;
        end
        else if (fn_serial_clock_ch0 == PF_SER_IN)
            drive[PIN_SERIAL_CLOCK_CH0] = 1'b0;
        if (fn_serial_clock_ch1 == PF_SER_OUT)
        begin
            drive[PIN_SERIAL_CLOCK_CH1] = 1'b1;
            val[PIN_SERIAL_CLOCK_CH1] = ctrl_ch1.serial_clock_out;
        end
        else if (fn_serial_clock_ch1 == PF_SER_IN)
            drive[PIN_SERIAL_CLOCK_CH1] = 1'b0;
    end

    always_comb
    begin
        next_q = q;
        if (awvalid && q.awready)
        begin
            next_q.aw_got = 1'b1;
            next_q.aw_sel = decode(awaddr);
        end
        if (wvalid && q.wready)
        begin
            next_q.w_got = 1'b1;
            next_q.wdata = wdata[PORT_W-1:0];
            next_q.wstrb0 = wstrb[0];
        end
        if (q.bvalid && bready)
            next_q.bvalid = 1'b0;
        if (wr_fire)
        begin
            next_q.aw_got = 1'b0;
            next_q.w_got = 1'b0;
            next_q.bvalid = 1'b1;
            next_q.bresp = (q.aw_sel == SEL_NONE) ? RESP_SLVERR : RESP_OKAY;
            if (q.wstrb0)
            begin
                // Readback index takes no write
                if (q.aw_sel == SEL_DIR)
                    next_q.pin_direction = q.wdata;
                else if (q.aw_sel == SEL_LAT)
                    next_q.output_latch = q.wdata;
                else if (q.aw_sel == SEL_OD)
                    next_q.open_drain_select = q.wdata;
            end
        end
        next_q.awready = !next_q.aw_got && !next_q.bvalid;
        next_q.wready = !next_q.w_got && !next_q.bvalid;

        if (q.rvalid && rready)
            next_q.rvalid = 1'b0;
        if (ar_fire)
        begin
            next_q.rvalid = 1'b1;
            next_q.rresp = RESP_OKAY;
            next_q.rdata = DATA_ZERO;
            if (ar_sel == SEL_PIN)
                next_q.rdata[PORT_W-1:0] = readback;
            else if (ar_sel == SEL_LAT)
                next_q.rdata[PORT_W-1:0] = q.output_latch;
            else if (ar_sel == SEL_OD)
                next_q.rdata[PORT_W-1:0] = q.open_drain_select;
            else if (ar_sel == SEL_NONE)
                next_q.rresp = RESP_SLVERR;
        end
        next_q.arready = !next_q.rvalid;

        // Standby wins over a write landing in the same cycle
        if (hw_standby)
        begin
            next_q.pin_direction = PORT_RESET;
            next_q.output_latch = PORT_RESET;
            next_q.open_drain_select = PORT_RESET;
        end

        // Open-drain pins only ever pull low, whatever drives them
        next_q.pin_out = val;
        next_q.pin_oe = drive & ~(q.open_drain_select & val);
        next_q.ret_ch0.receive_data = pin_in[PIN_RECEIVE_DATA_CH0];
        next_q.ret_ch1.receive_data = pin_in[PIN_RECEIVE_DATA_CH1];
        next_q.ret_ch0.serial_clock_in = pin_in[PIN_SERIAL_CLOCK_CH0];
        next_q.ret_ch1.serial_clock_in = pin_in[PIN_SERIAL_CLOCK_CH1];
    end

    // Power-on reset clears everything; hw_standby also resets direction, latch and open-drain select
    always_ff @(posedge sys_clk or negedge rst_b)
    begin
        if (!rst_b)
            q <= '0;
        else
            q <= next_q;
    end

    assign awready = q.awready;
    assign wready = q.wready;
    assign arready = q.arready;
    assign bvalid = q.bvalid;
    assign bresp = q.bresp;
    assign rvalid = q.rvalid;
    assign rdata = q.rdata;
    assign rresp = q.rresp;
    assign pin_out = q.pin_out;
    assign pin_oe = q.pin_oe;
    assign ret_ch0 = q.ret_ch0;
    assign ret_ch1 = q.ret_ch1;

    sequence s_serial_clock_ch1_out;
        !ctrl_ch1.clk_enable_high_bit && (ctrl_ch1.sync_mode || ctrl_ch1.clk_enable_low_bit);
    endsequence

    sequence s_pin_read;
        ar_fire && ar_sel == SEL_PIN;
    endsequence

    sequence s_serial_clock_ch0_out;
        !ctrl_ch0.clk_enable_high_bit && (ctrl_ch0.sync_mode || ctrl_ch0.clk_enable_low_bit);
    endsequence

    // Mode, clock enables, transmit and receive all off on both channels
    sequence s_released;
        ctrl_ch0[6:2] == 5'h00 && ctrl_ch1[6:2] == 5'h00;
    endsequence

    a_dir_drives_pin: assert property (
        @(posedge sys_clk) disable iff (!rst_b)
        !ctrl_ch0.receive_enable && q.pin_direction[PIN_RECEIVE_DATA_CH0] && !q.open_drain_select[PIN_RECEIVE_DATA_CH0]
        |=> pin_oe[PIN_RECEIVE_DATA_CH0] && pin_out[PIN_RECEIVE_DATA_CH0] == $past(q.output_latch[PIN_RECEIVE_DATA_CH0]))
        else $error("output pin not driven from latch");
    a_dir_reads_zero: assert property (
        @(posedge sys_clk) disable iff (!rst_b)
        ar_fire && ar_sel == SEL_DIR |=> rvalid && rdata == DATA_ZERO && rresp == RESP_OKAY)
        else $error("direction read not zero");
    a_standby_clears: assert property (
        @(posedge sys_clk) disable iff (!rst_b)
        hw_standby |=> q.pin_direction == PORT_RESET && q.output_latch == PORT_RESET
            && q.open_drain_select == PORT_RESET)
        else $error("standby did not clear registers");
    a_latch_write: assert property (
        @(posedge sys_clk) disable iff (!rst_b)
        wr_fire && q.aw_sel == SEL_LAT && q.wstrb0 && !hw_standby
        |=> q.output_latch == $past(q.wdata) && bvalid)
        else $error("latch write lost");
    a_reserved_zero: assert property (
        @(posedge sys_clk) disable iff (!rst_b)
        rvalid |-> rdata[DATA_W-1:PORT_W] == '0)
        else $error("reserved bits not zero");
    a_readback_mix: assert property (
        @(posedge sys_clk) disable iff (!rst_b)
        s_pin_read |=> rdata[PORT_W-1:0] == (($past(q.pin_direction) & $past(q.output_latch))
            | (~$past(q.pin_direction) & $past(pin_in))))
        else $error("readback mix wrong");
    a_open_drain_low: assert property (
        @(posedge sys_clk) disable iff (!rst_b)
        $past(rst_b) |-> ($past(q.open_drain_select) & pin_oe & pin_out) == '0)
        else $error("open-drain pin drove high");
    a_serial_clock_ch1_output: assert property (
        @(posedge sys_clk) disable iff (!rst_b)
        s_serial_clock_ch1_out ##0 !q.open_drain_select[PIN_SERIAL_CLOCK_CH1]
        |=> pin_oe[PIN_SERIAL_CLOCK_CH1] && pin_out[PIN_SERIAL_CLOCK_CH1] == $past(ctrl_ch1.serial_clock_out))
        else $error("clock output not on pin 5");
    a_receive_data_ch1_route: assert property (
        @(posedge sys_clk) disable iff (!rst_b)
        ctrl_ch1.receive_enable |=> !pin_oe[PIN_RECEIVE_DATA_CH1]
            && ret_ch1.receive_data == $past(pin_in[PIN_RECEIVE_DATA_CH1]))
        else $error("receive pin 3 misrouted");
    a_transmit_data_ch0_route: assert property (
        @(posedge sys_clk) disable iff (!rst_b)
        ctrl_ch0.transmit_enable |=> pin_out[PIN_TRANSMIT_DATA_CH0] == $past(ctrl_ch0.transmit_data))
        else $error("transmit pin 0 misrouted");
    a_serial_clock_ch0_output: assert property (
        @(posedge sys_clk) disable iff (!rst_b)
        s_serial_clock_ch0_out ##0 !q.open_drain_select[PIN_SERIAL_CLOCK_CH0]
        |=> pin_oe[PIN_SERIAL_CLOCK_CH0] && pin_out[PIN_SERIAL_CLOCK_CH0] == $past(ctrl_ch0.serial_clock_out))
        else $error("clock output not on pin 4");
    a_serial_clock_ch0_input: assert property (
        @(posedge sys_clk) disable iff (!rst_b)
        ctrl_ch0.clk_enable_high_bit |=> !pin_oe[PIN_SERIAL_CLOCK_CH0]
            && ret_ch0.serial_clock_in == $past(pin_in[PIN_SERIAL_CLOCK_CH0]))
        else $error("clock input pin 4 misrouted");
    a_serial_clock_ch1_input: assert property (
        @(posedge sys_clk) disable iff (!rst_b)
        ctrl_ch1.clk_enable_high_bit |=> !pin_oe[PIN_SERIAL_CLOCK_CH1]
            && ret_ch1.serial_clock_in == $past(pin_in[PIN_SERIAL_CLOCK_CH1]))
        else $error("clock input pin 5 misrouted");
    a_receive_data_ch0_route: assert property (
        @(posedge sys_clk) disable iff (!rst_b)
        ctrl_ch0.receive_enable |=> !pin_oe[PIN_RECEIVE_DATA_CH0]
            && ret_ch0.receive_data == $past(pin_in[PIN_RECEIVE_DATA_CH0]))
        else $error("receive pin 2 misrouted");
    a_transmit_data_ch1_route: assert property (
        @(posedge sys_clk) disable iff (!rst_b)
        ctrl_ch1.transmit_enable |=> pin_out[PIN_TRANSMIT_DATA_CH1] == $past(ctrl_ch1.transmit_data))
        else $error("transmit pin 1 misrouted");
    a_od_serial: assert property (
        @(posedge sys_clk) disable iff (!rst_b)
        ctrl_ch1.transmit_enable && ctrl_ch1.transmit_data && q.open_drain_select[PIN_TRANSMIT_DATA_CH1]
        |=> !pin_oe[PIN_TRANSMIT_DATA_CH1])
        else $error("open-drain serial pin drove high");
    a_regs_hold: assert property (
        @(posedge sys_clk) disable iff (!rst_b)
        !wr_fire && !hw_standby |=> $stable(q.pin_direction) && $stable(q.output_latch)
            && $stable(q.open_drain_select))
        else $error("register changed without a write");
    a_readback_no_write: assert property (
        @(posedge sys_clk) disable iff (!rst_b)
        wr_fire && q.aw_sel == SEL_PIN && !hw_standby |=> $stable(q.output_latch)
            && $stable(q.pin_direction) && $stable(q.open_drain_select))
        else $error("readback index took a write");
    a_released_gpio: assert property (
        @(posedge sys_clk) disable iff (!rst_b)
        s_released |=> pin_oe == ($past(q.pin_direction)
            & ~($past(q.open_drain_select) & $past(q.output_latch)))
            && pin_out == $past(q.output_latch))
        else $error("released pins not set by registers");

endmodule

`default_nettype wire

/* File: core/sio_pkg.sv */
// Constants and types for the six-bit I/O port with serial pin sharing.
// Assumes one system clock; register indices are scaled by four on the bus.
package sio_pkg;

    localparam int PORT_W = 6;
    localparam int REG_W = 8;
    localparam int DATA_W = 32;
    localparam int MIN_ADDR_W = 18;

    // Register indices; byte address is four times the index
    localparam logic [15:0] IDX_PIN_DIRECTION = 16'hFEB2;
    localparam logic [15:0] IDX_PIN_LEVEL_READBACK = 16'hFF52;
    localparam logic [15:0] IDX_OUTPUT_LATCH = 16'hFF62;
    localparam logic [15:0] IDX_OPEN_DRAIN_SELECT = 16'hFF76;

    localparam logic [PORT_W-1:0] PORT_RESET = 6'h00;
    localparam logic [DATA_W-1:0] DATA_ZERO = 32'h0000_0000;

    // Pin positions
    localparam int PIN_TRANSMIT_DATA_CH0 = 0;
    localparam int PIN_TRANSMIT_DATA_CH1 = 1;
    localparam int PIN_RECEIVE_DATA_CH0 = 2;
    localparam int PIN_RECEIVE_DATA_CH1 = 3;
    localparam int PIN_SERIAL_CLOCK_CH0 = 4;
    localparam int PIN_SERIAL_CLOCK_CH1 = 5;

    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;

    // Control levels arriving from one serial channel
    typedef struct packed {
        logic sync_mode;
        logic clk_enable_high_bit;
        logic clk_enable_low_bit;
        logic transmit_enable;
        logic receive_enable;
        logic transmit_data;
        logic serial_clock_out;
    } sio_ser_ctrl_t;

    // Levels returned to one serial channel
    typedef struct packed {
        logic receive_data;
        logic serial_clock_in;
    } sio_ser_ret_t;

    typedef enum logic [2:0] {
        SEL_NONE,
        SEL_DIR,
        SEL_PIN,
        SEL_LAT,
        SEL_OD
    } sio_sel_t;

    typedef enum logic [1:0] {
        PF_GPIO,
        PF_SER_OUT,
        PF_SER_IN
    } sio_pin_fn_t;

    typedef struct packed {
        logic awready;
        logic wready;
        logic arready;
        logic aw_got;
        logic w_got;
        sio_sel_t aw_sel;
        logic [PORT_W-1:0] wdata;
        logic wstrb0;
        logic bvalid;
        logic [1:0] bresp;
        logic rvalid;
        logic [1:0] rresp;
        logic [DATA_W-1:0] rdata;
        logic [PORT_W-1:0] pin_direction;
        logic [PORT_W-1:0] output_latch;
        logic [PORT_W-1:0] open_drain_select;
        logic [PORT_W-1:0] pin_out;
        logic [PORT_W-1:0] pin_oe;
        sio_ser_ret_t ret_ch0;
        sio_ser_ret_t ret_ch1;
    } sio_state_t;

endpackage

/* File: sim/sio_pins_model.sv */
// Far side of the port: external pin drivers with a weak pull-up.
// Assumes pin_oe high means the port drives the pin.
`timescale 1ns/1ps
`default_nettype none
module sio_pins_model (
    input wire logic [5:0] pin_out,
    input wire logic [5:0] pin_oe,
    input wire logic [5:0] ext_en,
    input wire logic [5:0] ext_val,
    output logic [5:0] pin_in
);
    // Port drive wins; a pin nobody drives floats up to the pull-up level
    assign pin_in = (pin_oe & pin_out) | (~pin_oe & ext_en & ext_val) | (~pin_oe & ~ext_en);
endmodule
`default_nettype wire

/* File: sim/sio_port_test.sv */
// Self-checking bench for the six-bit port with serial pin sharing.
// Assumes sio_pkg, sio_port and sio_pins_model are compiled before it.
`timescale 1ns/1ps
`default_nettype none
module sio_port_test;
    import sio_pkg::*;
    localparam logic [19:0] A_DIR = 20'h3FAC8;
    localparam logic [19:0] A_PIN = 20'h3FD48;
    localparam logic [19:0] A_LAT = 20'h3FD88;
    localparam logic [19:0] A_OD = 20'h3FDD8;
    logic sys_clk, rst_b, hw_standby, awvalid, wvalid, bready, arvalid, rready;
    logic awready, wready, bvalid, arready, rvalid;
    logic [19:0] awaddr, araddr;
    logic [31:0] wdata, rdata;
    logic [1:0] bresp, rresp;
    logic [5:0] pin_in, pin_out, pin_oe, ext_en, ext_val;
    sio_ser_ctrl_t ctrl_ch0, ctrl_ch1;
    sio_ser_ret_t ret_ch0, ret_ch1;
    int num_errors, n_tests;

    sio_port sio_port_inst (.sys_clk(sys_clk), .rst_b(rst_b), .hw_standby(hw_standby),
        .awvalid(awvalid), .awready(awready), .awaddr(awaddr), .awprot(3'h0),
        .wvalid(wvalid), .wready(wready), .wdata(wdata), .wstrb(4'hF),
        .bvalid(bvalid), .bready(bready), .bresp(bresp),
        .arvalid(arvalid), .arready(arready), .araddr(araddr), .arprot(3'h0),
        .rvalid(rvalid), .rready(rready), .rdata(rdata), .rresp(rresp),
        .pin_in(pin_in), .pin_out(pin_out), .pin_oe(pin_oe),
        .ctrl_ch0(ctrl_ch0), .ctrl_ch1(ctrl_ch1), .ret_ch0(ret_ch0), .ret_ch1(ret_ch1));
    sio_pins_model sio_pins_model_inst (.pin_out(pin_out), .pin_oe(pin_oe),
        .ext_en(ext_en), .ext_val(ext_val), .pin_in(pin_in));

    initial
    begin
        sys_clk = 1'b0;
        forever #2 sys_clk = ~sys_clk;
    end

    task automatic chk(input logic [31:0] s, input logic [31:0] e);
        n_tests++;
        if (s !== e)
        begin
            num_errors++;
            $display("MISMATCH t=%0t seen=%h exp=%h", $time, s, e);
        end
    endtask

    // Address and data offered together, each dropped once taken
    task automatic wr(input logic [19:0] a, input logic [31:0] d, input logic [1:0] er);
        @(posedge sys_clk);
        awaddr <= a;
        wdata <= d;
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        bready <= 1'b1;
        do
        begin
            @(posedge sys_clk);
            if (awvalid && awready) awvalid <= 1'b0;
            if (wvalid && wready) wvalid <= 1'b0;
        end while (!bvalid);
        chk(bresp, er);
        bready <= 1'b0;
    endtask

    task automatic rd(input logic [19:0] a, input logic [31:0] e, input logic [1:0] er);
        @(posedge sys_clk);
        araddr <= a;
        arvalid <= 1'b1;
        rready <= 1'b1;
        do
        begin
            @(posedge sys_clk);
            if (arvalid && arready) arvalid <= 1'b0;
        end while (!rvalid);
        chk(rdata, e);
        chk(rresp, er);
        rready <= 1'b0;
    endtask

    // Pins are registered: give the mux two edges to land
    task automatic settle();
        repeat (2) @(posedge sys_clk);
        #1;
    endtask

    task automatic t_reset();
        rd(A_DIR, 32'h0, RESP_OKAY);
        rd(A_LAT, 32'h0, RESP_OKAY);
        rd(A_OD, 32'h0, RESP_OKAY);
        rd(A_PIN, 32'h2A, RESP_OKAY);
        chk(pin_oe, 6'h00);
    endtask

    task automatic t_gpio();
        wr(A_LAT, 32'hFFFF_FFD5, RESP_OKAY);
        rd(A_LAT, 32'h15, RESP_OKAY);
        wr(A_DIR, 32'h0F, RESP_OKAY);
        settle();
        chk(pin_oe, 6'h0F);
        chk(pin_out & pin_oe, 6'h05);
        rd(A_PIN, 32'h25, RESP_OKAY);
        wr(A_PIN, 32'h0, RESP_OKAY);
        rd(A_PIN, 32'h25, RESP_OKAY);
    endtask

    task automatic t_open_drain();
        wr(A_DIR, 32'h3F, RESP_OKAY);
        wr(A_OD, 32'hFF, RESP_OKAY);
        rd(A_OD, 32'h3F, RESP_OKAY);
        settle();
        chk(pin_oe, 6'h2A);
        wr(A_OD, 32'h03, RESP_OKAY);
        settle();
        chk(pin_oe, 6'h3E);
    endtask

    task automatic t_serial();
        @(posedge sys_clk);
        ext_val <= 6'h2E;
        // Ch0: sync clock out low, receive, transmit 0
        ctrl_ch0 <= sio_ser_ctrl_t'(7'b1001100);
        // Ch1: external clock in, receive, transmit 1
        ctrl_ch1 <= sio_ser_ctrl_t'(7'b0101110);
        settle();
        chk(pin_oe, 6'h11);
        chk(pin_out & pin_oe, 6'h00);
        chk(ret_ch0.receive_data, 1'b1);
        chk(ret_ch1, 2'b11);
        @(posedge sys_clk);
        ext_val <= 6'h10;
        // Ch0: external clock in, transmit 1; ch1: async clock out high
        ctrl_ch0 <= sio_ser_ctrl_t'(7'b0101010);
        ctrl_ch1 <= sio_ser_ctrl_t'(7'b0010001);
        settle();
        chk(pin_oe, 6'h2E);
        chk(pin_out & pin_oe, 6'h24);
        chk(ret_ch0, 2'b11);
        chk(ret_ch1, 2'b01);
        @(posedge sys_clk);
        ctrl_ch0 <= sio_ser_ctrl_t'(7'h00);
        ctrl_ch1 <= sio_ser_ctrl_t'(7'h00);
        ext_val <= 6'h2A;
        settle();
        chk(pin_oe, 6'h3E);
        chk(pin_out & pin_oe, 6'h14);
    endtask

    task automatic t_standby();
        @(posedge sys_clk);
        hw_standby <= 1'b1;
        repeat (2) @(posedge sys_clk);
        hw_standby <= 1'b0;
        settle();
        chk(pin_oe, 6'h00);
        rd(A_LAT, 32'h0, RESP_OKAY);
        rd(A_OD, 32'h0, RESP_OKAY);
        rd(A_PIN, 32'h2A, RESP_OKAY);
    endtask

    task automatic t_bus_err();
        wr(20'h00010, 32'h3F, RESP_SLVERR);
        rd(20'h00010, 32'h0, RESP_SLVERR);
        wr(A_LAT, 32'h3F, RESP_OKAY);
        @(posedge sys_clk);
        rst_b <= 1'b0;
        repeat (2) @(posedge sys_clk);
        rst_b <= 1'b1;
        rd(A_LAT, 32'h0, RESP_OKAY);
    endtask

    task automatic end_sim();
        $display("Comparisons %0d, mismatches %0d", n_tests, num_errors);
        if (num_errors == 0 && n_tests > 0)
            $display("DONE - PASS");
        else
            $display("DONE - FAIL");
        $finish;
    endtask

    initial
    begin
        num_errors = 0;
        n_tests = 0;
        rst_b = 1'b0;
        hw_standby = 1'b0;
        {awvalid, wvalid, bready, arvalid, rready} = 5'h00;
        awaddr = 20'h0;
        araddr = 20'h0;
        wdata = 32'h0;
        ext_en = 6'h3F;
        ext_val = 6'h2A;
        ctrl_ch0 = sio_ser_ctrl_t'(7'h00);
        ctrl_ch1 = sio_ser_ctrl_t'(7'h00);
        repeat (4) @(posedge sys_clk);
        rst_b <= 1'b1;
        t_reset();
        t_gpio();
        t_open_drain();
        t_serial();
        t_standby();
        t_bus_err();
        end_sim();
    end

    // About a hundred cycles are expected; this is far beyond
    initial
    begin
        #40000;
        num_errors++;
        end_sim();
    end
endmodule
`default_nettype wire
